// ==== hw/etp_pkg.sv ====
package etp_pkg;

  // trigger control field encodings
  typedef enum logic [1:0] {
    ETP_MODE_ALL_IN  = 2'h0,
    ETP_MODE_EXT_IN  = 2'h1,
    ETP_MODE_OUT     = 2'h2,
    ETP_MODE_RSVD    = 2'h3
  } etp_mode_t;

  localparam logic [1:0] ETP_CTRL_RESET = 2'h0;

  localparam int unsigned ETP_CLK_MHZ = 100;

  // output pulse low time, ns
  localparam int unsigned ETP_PULSE_NS  = 125;
  localparam int unsigned ETP_PULSE_CYC = (ETP_PULSE_NS * ETP_CLK_MHZ) / 1000;

  // least low time the far end must hold, ns (rounded up)
  localparam int unsigned ETP_MIN_LOW_NS  = 250;
  localparam int unsigned ETP_MIN_LOW_CYC =
    (ETP_MIN_LOW_NS * ETP_CLK_MHZ + 999) / 1000;

  // longest low time before extra triggers may follow, ns (rounded down)
  localparam int unsigned ETP_MAX_LOW_NS  = 6000;
  localparam int unsigned ETP_MAX_LOW_CYC = (ETP_MAX_LOW_NS * ETP_CLK_MHZ) / 1000;

  // latest start of update after the falling edge, ns (rounded down)
  localparam int unsigned ETP_START_NS  = 6250;
  localparam int unsigned ETP_START_CYC = (ETP_START_NS * ETP_CLK_MHZ) / 1000;

  localparam int unsigned ETP_CNT_W = 10;

endpackage : etp_pkg

// ==== hw/etp_link_if.sv ====
`timescale 1ns/1ns
// one shared active-low trigger wire; either end may pull it low
interface etp_link_if;
  logic dev_o;
  logic dev_oe;
  logic src_o;
  logic src_oe;
  logic pin;

  // wired: a driving end pulls low, otherwise pulled up
  assign pin = ~((dev_oe & ~dev_o) | (src_oe & ~src_o));

  modport dev (
    input  pin,
    output dev_o,
    output dev_oe
  );

  modport src (
    input  pin,
    output src_o,
    output src_oe
  );
endinterface : etp_link_if

// ==== hw/etp_device.sv ====
`timescale 1ns/1ns
// Summary of operation
// - pin works as trigger input or output
// - outside source gives clean debounced low pulse
// - outside source holds low at least 250 ns
// - outside source releases low within 6 us
// - update starts within 6.25 us of fall
// - output mode drives active-low pulse per trigger
// - output pulse stays low about 125 ns
// - receivers use input, external-only mode
// - mode 00 accepts external, software, timer triggers
// - mode 01 accepts external triggers only
// - mode 10 drives software, timer triggers out
// - reset clears control field to 00
module etp_device
  import etp_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // control
  input  wire logic [1:0] trig_ctrl,
  input  wire logic       ctrl_we,
  input  wire logic       sw_trig,
  input  wire logic       timer_trig,
  // status
  output logic      [1:0] ctrl_field,
  output logic            update_start,
  // link
  etp_link_if.dev         link
);
  import etp_pkg::*;

  // pulse generator states
  typedef enum logic [1:0] {
    ETP_IDLE,
    ETP_DRIVE,
    ETP_WAIT_HIGH
  } etp_state_t;

  // control field
  logic [1:0]           ctrl_q;
  logic [1:0]           ctrl_d;

  // pin synchroniser and edge detector
  logic                 sync1_q;
  logic                 sync1_d;
  logic                 sync2_q;
  logic                 sync2_d;
  logic                 prev_q;
  logic                 prev_d;

  // output pulse generator
  etp_state_t           state_q;
  etp_state_t           state_d;
  logic [ETP_CNT_W-1:0] cnt_q;
  logic [ETP_CNT_W-1:0] cnt_d;
  logic                 drv_q;
  logic                 drv_d;

  // update strobe
  logic                 upd_q;
  logic                 upd_d;

  // decoded conditions
  logic                 fall;
  logic                 int_trig;
  logic                 idle;
  logic                 start_pulse;
  logic                 ext_hit;
  logic                 int_hit;

  // output mode only when field is 10
  function automatic logic is_out(input logic [1:0] m);
    return m == ETP_MODE_OUT;
  endfunction : is_out

  // pin edges count in 00 and 01 only
  function automatic logic ext_ok(input logic [1:0] m);
    return (m == ETP_MODE_ALL_IN) || (m == ETP_MODE_EXT_IN);
  endfunction : ext_ok

  // local software and timer updates without a pulse only in 00
  function automatic logic int_ok(input logic [1:0] m);
    return m == ETP_MODE_ALL_IN;
  endfunction : int_ok

  // code 11 matches no function and so does nothing
  assign fall        = prev_q & ~sync2_q;
  assign int_trig    = sw_trig | timer_trig;
  assign idle        = (state_q == ETP_IDLE);
  assign start_pulse = idle & is_out(ctrl_q) & int_trig;
  assign ext_hit     = idle & ext_ok(ctrl_q) & fall;
  assign int_hit     = idle & int_ok(ctrl_q) & int_trig;

  // control field loads on the write strobe
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_we) begin
      // 11 is stored as written but decodes to nothing
      ctrl_d = trig_ctrl;
    end
  end

  // reset leaves input mode with every source enabled
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= ETP_CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // only the second and third stages feed logic; the first may be metastable
  always_comb begin
    sync1_d = link.pin;
    sync2_d = sync1_q;
    prev_d  = sync2_q;
  end

  // preset to the idle high level so release gives no false edge
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q  <= 1'b1;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q  <= prev_d;
    end
  end

  // triggers arriving during a pulse or its read-back are dropped
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    drv_d   = drv_q;
    case (state_q)
      ETP_IDLE: begin
        if (start_pulse) begin
          // pin goes low on the next edge
          state_d = ETP_DRIVE;
          cnt_d   = ETP_CNT_W'(ETP_PULSE_CYC - 1);
          drv_d   = 1'b1;
        end
      end
      ETP_DRIVE: begin
        if (cnt_q == '0) begin
          // 12 cycles, 120 ns: typical width rounded down
          state_d = ETP_WAIT_HIGH;
          drv_d   = 1'b0;
        end else begin
          cnt_d = cnt_q - ETP_CNT_W'(1);
        end
      end
      ETP_WAIT_HIGH: begin
        // own pulse must not read back as an external edge
        if (sync2_q && prev_q) begin
          state_d = ETP_IDLE;
        end
      end
      default: begin
        state_d = ETP_IDLE;
        drv_d   = 1'b0;
      end
    endcase
  end

  // a reset mid pulse releases the pin on that same edge
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ETP_IDLE;
      cnt_q   <= '0;
      drv_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      drv_q   <= drv_d;
    end
  end

  // one strobe per accepted trigger; three edges after a pin fall,
  // far inside the 6.25 us limit
  always_comb begin
    upd_d = 1'b0;
    // output mode updates locally together with the pulse start
    if (start_pulse || ext_hit || int_hit) begin
      upd_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= upd_d;
    end
  end

  // open-drain style: level fixed low, the enable does the driving
  assign link.dev_o    = 1'b0;
  assign link.dev_oe   = drv_q;
  assign ctrl_field    = ctrl_q;
  assign update_start  = upd_q;
endmodule : etp_device

// ==== hw/etp_source.sv ====
`timescale 1ns/1ns
// far end: an outside trigger source or a receiving module
module etp_source
  import etp_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // request
  input  wire logic fire,
  output logic      busy,
  // receive side
  output logic      rx_trig,
  // link
  etp_link_if.src   link
);
  import etp_pkg::*;

  // hold low 400 ns: above the least, far below the longest
  localparam int unsigned HOLD_CYC = ETP_MIN_LOW_CYC + 15;

  logic [ETP_CNT_W-1:0] cnt_q, cnt_d;
  logic                 drv_q, drv_d;
  logic                 s1_q, s2_q, p_q, rx_q;
  logic                 s1_d, s2_d, p_d, rx_d;

  always_comb begin
    cnt_d = cnt_q;
    drv_d = drv_q;
    if (drv_q) begin
      if (cnt_q == '0) begin
        drv_d = 1'b0;                            // single clean edge
      end else begin
        cnt_d = cnt_q - ETP_CNT_W'(1);
      end
    end else if (fire) begin
      drv_d = 1'b1;
      cnt_d = ETP_CNT_W'(HOLD_CYC - 1);
    end
    s1_d = link.pin;
    s2_d = s1_q;
    p_d  = s2_q;
    // as a receiver it never drives while idle
    rx_d = p_q & ~s2_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      drv_q <= 1'b0;
      s1_q  <= 1'b1;
      s2_q  <= 1'b1;
      p_q   <= 1'b1;
      rx_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      drv_q <= drv_d;
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      p_q   <= p_d;
      rx_q  <= rx_d;
    end
  end

  assign link.src_o  = 1'b0;
  assign link.src_oe = drv_q;
  assign busy        = drv_q;
  assign rx_trig     = rx_q;
endmodule : etp_source

// ==== verif/etp_chk.sv ====
`timescale 1ns/1ns
module etp_chk
  import etp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // link
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic src_o,
  input wire logic src_oe,
  input wire logic pin
);
  import etp_pkg::*;
  logic [3:0] low_q;
  logic [3:0] low_d;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // saturates so a stuck drive cannot wrap round and hide
  always_comb low_d = dev_oe ? ((low_q == 4'hf) ? low_q : low_q + 4'h1) : 4'h0;
  always_ff @(posedge clk) low_q <= srst ? 4'h0 : low_d;

  property p_rst; @(posedge clk) disable iff (1'b0) srst |=> !dev_oe; endproperty
  a_rst: assert property (p_rst) else $error("drive seen after reset");
  property p_drv; dev_oe |-> !dev_o; endproperty
  a_drv: assert property (p_drv) else $error("driven level not low");
  property p_pin; dev_oe |-> !pin; endproperty
  a_pin: assert property (p_pin) else $error("pin high while driven");
  property p_max; dev_oe |-> low_q < 4'(ETP_PULSE_CYC); endproperty
  a_max: assert property (p_max) else $error("pulse too long");
  property p_len; $fell(dev_oe) && !$past(srst) |-> low_q == 4'(ETP_PULSE_CYC); endproperty
  a_len: assert property (p_len) else $error("pulse length wrong");
  property p_gap; $fell(dev_oe) |=> !dev_oe [*2]; endproperty
  a_gap: assert property (p_gap) else $error("pulses too close");
  property p_idle; (!dev_oe || dev_o) && (!src_oe || src_o) |-> pin; endproperty
  a_idle: assert property (p_idle) else $error("released pin not high");
  property p_rise; $rose(dev_oe) |-> $past(pin); endproperty
  a_rise: assert property (p_rise) else $error("drive began on low pin");
endmodule : etp_chk

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  import etp_pkg::*;
  logic       clk = 0, srst = 1, ctrl_we = 0, sw_trig = 0, timer_trig = 0, fire = 0;
  logic [1:0] trig_ctrl = 2'h0;
  logic [1:0] ctrl_field;
  logic       update_start, busy, rx_trig;
  int         bad_count = 0, n_tests = 0, cyc = 0;
  etp_link_if link ();
  etp_device i_etp_device (.clk(clk), .srst(srst), .trig_ctrl(trig_ctrl), .ctrl_we(ctrl_we),
    .sw_trig(sw_trig), .timer_trig(timer_trig), .ctrl_field(ctrl_field),
    .update_start(update_start), .link(link.dev));
  etp_source i_etp_source (.clk(clk), .srst(srst), .fire(fire), .busy(busy),
    .rx_trig(rx_trig), .link(link.src));
  etp_chk i_etp_chk (.clk(clk), .srst(srst), .dev_o(link.dev_o), .dev_oe(link.dev_oe),
    .src_o(link.src_o), .src_oe(link.src_oe), .pin(link.pin));
  always #5 clk = ~clk;
  // whole run is about 750 cycles; the 3000-cycle limit is four times that
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("errors %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task chk(logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : chk
  task set_mode(logic [1:0] m);
    @(posedge clk); #1 trig_ctrl = m; ctrl_we = 1;
    @(posedge clk); #1 ctrl_we = 0;
    chk({6'h0, ctrl_field}, {6'h0, m});
  endtask : set_mode
  // one trigger, then count updates, low pin cycles and far-end receptions
  task run(logic [1:0] m, logic s, logic t, logic f, logic [7:0] eu, logic [7:0] el);
    logic [7:0] nu, nl, nr, nb, lat;
    set_mode(m);
    nu = 0; nl = 0; nr = 0; nb = 0; lat = 0;
    @(posedge clk); #1 sw_trig = s; timer_trig = t; fire = f;
    @(posedge clk); #1 sw_trig = 0; timer_trig = 0; fire = 0;
    repeat (70) begin
      nu += update_start; nl += !link.pin; nr += rx_trig;
      nb += busy;
      if (nu == 0) lat++;
      @(posedge clk); #1;
    end
    chk(nu, eu);
    chk(nl, el);
    chk(nb, f ? 8'h28 : 8'h00);
    if (!f) chk(nr, {7'h0, el != 0});
    if (eu != 0) chk({7'h0, lat <= 8'd5}, 8'h1);
  endtask : run
  initial begin
    repeat (4) @(posedge clk);
    #1 srst = 0;
    chk({6'h0, ctrl_field}, 8'h0);
    run(2'h0, 0, 0, 1, 8'd1, 8'd40);
    run(2'h0, 1, 0, 0, 8'd1, 8'd0);
    run(2'h0, 0, 1, 0, 8'd1, 8'd0);
    run(2'h1, 0, 0, 1, 8'd1, 8'd40);
    run(2'h1, 1, 0, 0, 8'd0, 8'd0);
    run(2'h1, 0, 1, 0, 8'd0, 8'd0);
    run(2'h2, 1, 0, 0, 8'd1, 8'd12);
    run(2'h2, 0, 1, 0, 8'd1, 8'd12);
    run(2'h2, 0, 0, 1, 8'd0, 8'd40);
    run(2'h3, 1, 1, 0, 8'd0, 8'd0);
    // reset cuts a driven pulse: pin stays low until the next clock edge, then must be high
    set_mode(2'h2);
    @(posedge clk); #1 sw_trig = 1;
    @(posedge clk); #1 sw_trig = 0;
    repeat (3) @(posedge clk);
    #1 srst = 1;
    chk({7'h0, link.pin}, 8'h0);
    @(posedge clk); #1 srst = 0;
    chk({6'h0, ctrl_field}, 8'h0);
    chk({6'h0, link.pin, update_start}, 8'h2);
    wrap_up();
  end
endmodule : tb_top
